// >>> gpd_map.svh
// Register offsets, field positions, reset values and limits of the gear and pulse divider
`ifndef GPD_MAP_SVH
`define GPD_MAP_SVH

`define GPD_OFF_CTRL      12'h000
`define GPD_OFF_GEAR_NUM  12'h004
`define GPD_OFF_GEAR_DEN  12'h008
`define GPD_OFF_OUT_CNT   12'h00C
`define GPD_OFF_OUT_DEN   12'h010
`define GPD_OFF_OUT_LOGIC 12'h014
`define GPD_OFF_STATUS    12'h018
`define GPD_OFF_IRQ_MASK  12'h01C
`define GPD_OFF_ACTIVE    12'h020

`define GPD_CTRL_FC_BIT      0
`define GPD_CTRL_RESTART_BIT 1
`define GPD_ST_MULT_BIT      0
`define GPD_ST_HYB_BIT       1
`define GPD_LOGIC_BINV_BIT   0
`define GPD_LOGIC_SCALE_BIT  1

`define GPD_RST_GEAR_NUM  32'h0000_0000
`define GPD_RST_GEAR_DEN  32'h0000_2710
`define GPD_RST_OUT_CNT   32'h0000_09C4
`define GPD_RST_OUT_DEN   32'h0000_0000
`define GPD_RST_OUT_LOGIC 2'h0

`define GPD_GEAR_MAX      32'h4000_0000
`define GPD_OUT_CNT_MAX   32'h0020_0000
`define GPD_OUT_DEN_MAX   32'h0080_0000
`define GPD_ENC_RES       32'h0080_0000
`endif

// >>> gpd_pkg.sv
// Types shared by the gear and pulse divider modules
package gpd_pkg;
   typedef logic [31:0] gpd_word_t;
   typedef enum logic {GPD_SRC_ENC, GPD_SRC_SCALE} gpd_src_e;
endpackage

// >>> gpd_step_if.sv
// Step event carrier between the ratio accumulators and their consumers
`timescale 1ns/1ps
interface gpd_step_if;
   logic ev;
   logic dir;
   modport src (output ev, output dir);
   modport snk (input ev, input dir);
endinterface

// >>> gpd_ratio_acc.sv
// Fractional ratio accumulator: each forward input step adds num, each reverse one subtracts it, one output step per den
`timescale 1ns/1ps
module gpd_ratio_acc
   import gpd_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic resetn_i,
   // Ratio
   input  wire gpd_word_t num_i,
   input  wire gpd_word_t den_i,
   // Input steps, dir high means reverse
   input  wire logic in_ev_i,
   input  wire logic in_dir_i,
   // Output steps and overload flag
   gpd_step_if.src   out,
   output logic      overrun_o
);
   logic signed [34:0] acc_q;
   logic signed [34:0] acc_d;
   logic signed [34:0] num_s;
   logic signed [34:0] den_s;
   logic               fwd_due;
   logic               rev_due;

   assign num_s   = $signed({3'h0, num_i});
   assign den_s   = $signed({3'h0, den_i});
   assign fwd_due = (acc_q >= den_s);
   assign rev_due = (acc_q <= -den_s);
   // A new step while the previous one is still being paid out is an overload
   assign overrun_o = in_ev_i & (fwd_due | rev_due);

   always_comb begin
      acc_d = acc_q;
      if (fwd_due) begin
         acc_d = acc_d - den_s;
      end else if (rev_due) begin
         acc_d = acc_d + den_s;
      end
      if (in_ev_i) begin
         acc_d = in_dir_i ? (acc_d - num_s) : (acc_d + num_s);
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         acc_q <= '0;
      end else begin
         acc_q <= acc_d;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         out.ev  <= 1'b0;
         out.dir <= 1'b0;
      end else begin
         out.ev  <= fwd_due | rev_due;
         out.dir <= rev_due;
      end
   end
endmodule

// >>> gpd_quad_gen.sv
// Quadrature pulse generator driven by step events
`timescale 1ns/1ps
module gpd_quad_gen
   import gpd_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic resetn_i,
   // Steps and options
   gpd_step_if.snk   in,
   input  wire logic b_inv_i,
   input  wire logic z_src_i,
   // Pulse outputs
   output logic      a_o,
   output logic      b_o,
   output logic      z_o
);
   logic [1:0] ph_q;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ph_q <= 2'h0;
      end else if (in.ev) begin
         ph_q <= in.dir ? (ph_q - 2'h1) : (ph_q + 2'h1);
      end
   end

   // Gray order keeps exactly one line changing per edge
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         a_o <= 1'b0;
         b_o <= 1'b0;
         z_o <= 1'b0;
      end else begin
         a_o <= ph_q[1];
         b_o <= ph_q[1] ^ ph_q[0] ^ b_inv_i;
         z_o <= z_src_i;
      end
   end
endmodule

// >>> gpd_top.sv
// Electronic gear for command pulses and divided quadrature pulse regeneration
`timescale 1ns/1ps
`include "gpd_map.svh"
module gpd_top
   import gpd_pkg::*;
#(
   parameter gpd_word_t ENC_RES = `GPD_ENC_RES
)
(
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        resetn_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Command pulse pins from the host
   input  wire logic        cmd_pulse_i,
   input  wire logic        cmd_sign_i,
   // Scaled command towards the position loop
   output logic             pos_cmd_step_o,
   output logic             pos_cmd_dir_o,
   // Encoder feedback pins
   input  wire logic        enc_a_i,
   input  wire logic        enc_b_i,
   input  wire logic        enc_z_i,
   // External scale pins
   input  wire logic        scl_a_i,
   input  wire logic        scl_b_i,
   input  wire logic        scl_z_i,
   // Regenerated pulse outputs to the host
   output logic             regen_a_phase_o,
   output logic             regen_b_phase_o,
   output logic             regen_z_phase_o,
   // Interrupt
   output logic             irq_o
);
   // Pin synchronisers
   localparam int NPIN = 8;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_s1_q;
   logic [NPIN-1:0] pin_s2_q;
   logic [NPIN-1:0] pin_prev_q;

   // Bus registers; only the output settings are staged
   logic              full_closed_q;
   gpd_word_t         gear_num_q;
   gpd_word_t         gear_den_q;
   gpd_word_t         out_cnt_q;
   gpd_word_t         out_den_q;
   logic [1:0]        out_logic_q;
   logic [1:0]        status_q;
   logic [1:0]        irq_mask_q;
   // Values in force for the pulse output
   gpd_word_t         act_cnt_q;
   gpd_word_t         act_den_q;
   logic [1:0]        act_logic_q;
   logic [31:0]       prdata_q;

   // Bus decode
   logic              wr_en;
   logic              rd_setup;
   logic              hit;
   logic              restart;
   logic              gear_wr;

   // Step paths
   logic              cmd_ev;
   logic [1:0]        enc_dec;
   logic [1:0]        scl_dec;
   gpd_src_e          src_sel;
   logic              src_ev;
   logic              src_dir;
   gpd_word_t         cmd_num;
   gpd_word_t         cmd_den;
   gpd_word_t         div_num;
   gpd_word_t         div_den;
   gpd_word_t         lim_num;
   logic              mult_ovr;
   logic              mult_err_ev;
   logic              hyb_ev;
   logic [1:0]        ev_vec;

   gpd_step_if cmd_step ();
   gpd_step_if div_step ();

   // Quadrature decode, returns {step, reverse}
   function automatic logic [1:0] quad_dec(input logic [1:0] prev_ab, input logic [1:0] cur_ab);
      logic [1:0] p;
      logic [1:0] c;
      logic [1:0] d;
      p = {prev_ab[1], prev_ab[1] ^ prev_ab[0]};
      c = {cur_ab[1], cur_ab[1] ^ cur_ab[0]};
      d = c - p;
      case (d)
         2'h1:    quad_dec = 2'b10;
         2'h3:    quad_dec = 2'b11;
         default: quad_dec = 2'b00;
      endcase
   endfunction

   // Saturating write for range-limited settings
   function automatic gpd_word_t clamp(input gpd_word_t v, input gpd_word_t max);
      clamp = (v > max) ? max : v;
   endfunction

   assign pin_raw = {cmd_pulse_i, cmd_sign_i, enc_a_i, enc_b_i, enc_z_i,
                     scl_a_i, scl_b_i, scl_z_i};

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_s1_q   <= '0;
         pin_s2_q   <= '0;
         pin_prev_q <= '0;
      end else begin
         pin_s1_q   <= pin_raw;
         pin_s2_q   <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
      end
   end

   // APB decode; zero wait states, answer in the access phase
   assign wr_en    = psel_i & penable_i & pwrite_i;
   assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
   assign pready_o = 1'b1;
   always_comb begin
      case (paddr_i)
         `GPD_OFF_CTRL, `GPD_OFF_GEAR_NUM, `GPD_OFF_GEAR_DEN,
         `GPD_OFF_OUT_CNT, `GPD_OFF_OUT_DEN, `GPD_OFF_OUT_LOGIC,
         `GPD_OFF_STATUS, `GPD_OFF_IRQ_MASK, `GPD_OFF_ACTIVE: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign pslverr_o = psel_i & penable_i & ~hit;
   assign prdata_o  = prdata_q;
   assign restart   = wr_en & (paddr_i == `GPD_OFF_CTRL) & pwdata_i[`GPD_CTRL_RESTART_BIT];
   assign gear_wr   = wr_en & ((paddr_i == `GPD_OFF_GEAR_NUM) |
                               (paddr_i == `GPD_OFF_GEAR_DEN));

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         full_closed_q <= 1'b0;
      end else if (wr_en && paddr_i == `GPD_OFF_CTRL) begin
         full_closed_q <= pwdata_i[`GPD_CTRL_FC_BIT];
      end
   end

   // Gear registers act at once; only the change itself is policed
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gear_num_q <= `GPD_RST_GEAR_NUM;
         gear_den_q <= `GPD_RST_GEAR_DEN;
      end else if (wr_en) begin
         if (paddr_i == `GPD_OFF_GEAR_NUM) begin
            gear_num_q <= clamp(pwdata_i, `GPD_GEAR_MAX);
         end
         if (paddr_i == `GPD_OFF_GEAR_DEN) begin
            gear_den_q <= clamp(pwdata_i, `GPD_GEAR_MAX);
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         out_cnt_q   <= `GPD_RST_OUT_CNT;
         out_den_q   <= `GPD_RST_OUT_DEN;
         out_logic_q <= `GPD_RST_OUT_LOGIC;
      end else if (wr_en) begin
         if (paddr_i == `GPD_OFF_OUT_CNT) begin
            out_cnt_q <= clamp(pwdata_i, `GPD_OUT_CNT_MAX);
         end
         if (paddr_i == `GPD_OFF_OUT_DEN) begin
            out_den_q <= clamp(pwdata_i, `GPD_OUT_DEN_MAX);
         end
         if (paddr_i == `GPD_OFF_OUT_LOGIC) begin
            out_logic_q <= pwdata_i[1:0];
         end
      end
   end

   // Output settings only load on a control restart, never mid-run
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         act_cnt_q   <= `GPD_RST_OUT_CNT;
         act_den_q   <= `GPD_RST_OUT_DEN;
         act_logic_q <= `GPD_RST_OUT_LOGIC;
      end else if (restart) begin
         act_cnt_q   <= out_cnt_q;
         act_den_q   <= out_den_q;
         act_logic_q <= out_logic_q;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_mask_q <= 2'h0;
      end else if (wr_en && paddr_i == `GPD_OFF_IRQ_MASK) begin
         irq_mask_q <= pwdata_i[1:0];
      end
   end

   // Sticky status, a new event wins over a same-cycle clear
   assign hyb_ev = gear_wr & full_closed_q;
   assign mult_err_ev = mult_ovr;
   always_comb begin
      ev_vec = 2'h0;
      ev_vec[`GPD_ST_MULT_BIT] = mult_err_ev;
      ev_vec[`GPD_ST_HYB_BIT]  = hyb_ev;
   end
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         status_q <= 2'h0;
      end else if (wr_en && paddr_i == `GPD_OFF_STATUS) begin
         status_q <= (status_q & ~pwdata_i[1:0]) | ev_vec;
      end else begin
         status_q <= status_q | ev_vec;
      end
   end
   assign irq_o = |(status_q & irq_mask_q);

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prdata_q <= 32'h0000_0000;
      end else if (rd_setup) begin
         case (paddr_i)
            `GPD_OFF_CTRL:      prdata_q <= {31'h0, full_closed_q};
            `GPD_OFF_GEAR_NUM:  prdata_q <= gear_num_q;
            `GPD_OFF_GEAR_DEN:  prdata_q <= gear_den_q;
            `GPD_OFF_OUT_CNT:   prdata_q <= out_cnt_q;
            `GPD_OFF_OUT_DEN:   prdata_q <= out_den_q;
            `GPD_OFF_OUT_LOGIC: prdata_q <= {30'h0, out_logic_q};
            `GPD_OFF_STATUS:    prdata_q <= {30'h0, status_q};
            `GPD_OFF_IRQ_MASK:  prdata_q <= {30'h0, irq_mask_q};
            `GPD_OFF_ACTIVE:    prdata_q <= {29'h0, src_sel == GPD_SRC_SCALE, act_logic_q};
            default:            prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // Command gear: counts-per-rev has no say here, only the gear pair
   assign cmd_ev = pin_s2_q[7] & ~pin_prev_q[7];
   always_comb begin
      if (gear_num_q == 32'h0000_0000) begin
         cmd_num = 32'h0000_0001;
         cmd_den = 32'h0000_0001;
      end else begin
         cmd_num = gear_num_q;
         cmd_den = (gear_den_q == 32'h0000_0000) ? 32'h0000_0001 : gear_den_q;
      end
   end

   gpd_ratio_acc u_cmd_acc (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .num_i     (cmd_num),
      .den_i     (cmd_den),
      .in_ev_i   (cmd_ev),
      .in_dir_i  (pin_s2_q[6]),
      .out       (cmd_step),
      .overrun_o (mult_ovr)
   );
   assign pos_cmd_step_o = cmd_step.ev;
   assign pos_cmd_dir_o  = cmd_step.dir;

   // Feedback source; the scale is honoured only under full-closed control
   assign enc_dec = quad_dec(pin_prev_q[5:4], pin_s2_q[5:4]);
   assign scl_dec = quad_dec(pin_prev_q[2:1], pin_s2_q[2:1]);
   assign src_sel = (full_closed_q && act_logic_q[`GPD_LOGIC_SCALE_BIT]) ?
                    GPD_SRC_SCALE : GPD_SRC_ENC;
   assign src_ev  = (src_sel == GPD_SRC_SCALE) ? scl_dec[1] : enc_dec[1];
   assign src_dir = (src_sel == GPD_SRC_SCALE) ? scl_dec[0] : enc_dec[0];

   // Edges out per source count; ratio is capped at one so nothing multiplies
   always_comb begin
      if (act_den_q != 32'h0000_0000) begin
         lim_num = act_cnt_q;
         div_den = act_den_q;
      end else if (src_sel == GPD_SRC_SCALE) begin
         lim_num = 32'h0000_0001;
         div_den = 32'h0000_0001;
      end else begin
         lim_num = {act_cnt_q[29:0], 2'b00};
         div_den = ENC_RES;
      end
      div_num = (lim_num > div_den) ? div_den : lim_num;
   end

   gpd_ratio_acc u_div_acc (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .num_i     (div_num),
      .den_i     (div_den),
      .in_ev_i   (src_ev),
      .in_dir_i  (src_dir),
      .out       (div_step),
      .overrun_o ()
   );

   // Index is passed straight from the chosen source, not realigned to A
   gpd_quad_gen u_quad (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .in        (div_step),
      .b_inv_i   (act_logic_q[`GPD_LOGIC_BINV_BIT]),
      .z_src_i   ((src_sel == GPD_SRC_SCALE) ? pin_s2_q[0] : pin_s2_q[3]),
      .a_o       (regen_a_phase_o),
      .b_o       (regen_b_phase_o),
      .z_o       (regen_z_phase_o)
   );
endmodule

// >>> gpd_checker.sv
// Port-level assertions for the gear and pulse divider
`timescale 1ns/1ps
module gpd_checker (
   // Ports of the top module
   input wire logic        ref_clk_i, resetn_i, psel_i, penable_i, pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i, prdata_o,
   input wire logic        pready_o, pslverr_o, cmd_pulse_i, cmd_sign_i,
   input wire logic        pos_cmd_step_o, pos_cmd_dir_o, enc_a_i, enc_b_i, enc_z_i,
   input wire logic        scl_a_i, scl_b_i, scl_z_i, regen_a_phase_o, regen_b_phase_o,
   input wire logic        regen_z_phase_o, irq_o
);
   logic [10:0] since_cmd, since_src, since_z;
   logic        cmd_q, sign_cap;
   logic [3:0]  src_q;
   wire         unmap = psel_i && penable_i && paddr_i > 12'h020;
   wire         mapped = psel_i && penable_i && paddr_i <= 12'h020 && paddr_i[1:0] == 2'h0;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   // Counters saturate so a long idle span never wraps into a false pass
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         since_cmd <= 11'h7FF;
         since_src <= 11'h7FF;
         since_z   <= 11'h7FF;
         cmd_q     <= 1'b0;
         sign_cap  <= 1'b0;
         src_q     <= 4'h0;
      end else begin
         cmd_q <= cmd_pulse_i;
         src_q <= {enc_a_i, enc_b_i, scl_a_i, scl_b_i};
         if (cmd_pulse_i && !cmd_q) sign_cap <= cmd_sign_i;
         since_cmd <= (cmd_pulse_i && !cmd_q) ? 11'h000 : since_cmd + {10'h0, ~&since_cmd};
         since_src <= (src_q != {enc_a_i, enc_b_i, scl_a_i, scl_b_i}) ? 11'h000 :
                      since_src + {10'h0, ~&since_src};
         since_z <= (enc_z_i || scl_z_i) ? 11'h000 : since_z + {10'h0, ~&since_z};
      end
   end
   a_pready_high: assert property (pready_o) else $error("pready low");
   a_unmap_err: assert property (unmap |-> pslverr_o) else $error("no error on unmapped");
   a_map_ok: assert property (mapped |-> !pslverr_o) else $error("error on mapped access");
   a_unmap_rd_zero: assert property (unmap && !pwrite_i |-> prdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_step_cause: assert property (pos_cmd_step_o |-> since_cmd < 11'd1100)
      else $error("step without command");
   a_step_dir: assert property (pos_cmd_step_o |-> pos_cmd_dir_o == sign_cap)
      else $error("step direction wrong");
   a_quad_single: assert property (!($changed(regen_a_phase_o) && $changed(regen_b_phase_o)))
      else $error("both phases moved");
   a_edge_has_source: assert property ($changed(regen_a_phase_o) |-> since_src <= 11'd12)
      else $error("output edge without source edge");
   a_index_follows: assert property ($rose(regen_z_phase_o) |-> since_z <= 11'd6)
      else $error("index without source index");
endmodule
bind gpd_top gpd_checker u_gpd_checker (
   .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .cmd_pulse_i(cmd_pulse_i),
   .cmd_sign_i(cmd_sign_i), .pos_cmd_step_o(pos_cmd_step_o), .pos_cmd_dir_o(pos_cmd_dir_o),
   .enc_a_i(enc_a_i), .enc_b_i(enc_b_i), .enc_z_i(enc_z_i), .scl_a_i(scl_a_i),
   .scl_b_i(scl_b_i), .scl_z_i(scl_z_i), .regen_a_phase_o(regen_a_phase_o),
   .regen_b_phase_o(regen_b_phase_o), .regen_z_phase_o(regen_z_phase_o), .irq_o(irq_o));

// >>> gpd_host_model.sv
// Host model: command pulse train source and regenerated pulse monitor
`timescale 1ns/1ps
module gpd_host_model (
   // Control from the bench
   input  wire logic       ref_clk_i, resetn_i, start_i, rev_i,
   input  wire logic [7:0] n_i, gap_i,
   // Regenerated pulses
   input  wire logic       a_i, b_i, z_i,
   // Command pins and monitor results
   output logic            cmd_pulse_o, cmd_sign_o, busy_o, b_at_rise_o,
   output logic [15:0]     edges_o, zc_o
);
   logic [7:0] left, tmr;
   logic       a_q, b_q;
   // Sign is set one cycle ahead of the first pulse and held afterwards
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         left <= 8'h00;
         tmr <= 8'h00;
         cmd_pulse_o <= 1'b0;
         cmd_sign_o <= 1'b0;
         busy_o <= 1'b0;
      end else if (start_i && !busy_o) begin
         left <= n_i;
         cmd_sign_o <= rev_i;
         busy_o <= 1'b1;
      end else if (busy_o) begin
         if (tmr != 8'h00) tmr <= tmr - 8'h01;
         else if (cmd_pulse_o) begin
            cmd_pulse_o <= 1'b0;
            tmr <= gap_i;
         end else if (left != 8'h00) begin
            cmd_pulse_o <= 1'b1;
            left <= left - 8'h01;
            tmr <= 8'h01;
         end else busy_o <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         a_q <= 1'b0;
         b_q <= 1'b0;
         edges_o <= 16'h0000;
         zc_o <= 16'h0000;
         b_at_rise_o <= 1'b0;
      end else begin
         a_q <= a_i;
         b_q <= b_i;
         edges_o <= edges_o + {15'h0, a_i ^ a_q} + {15'h0, b_i ^ b_q};
         zc_o <= zc_o + {15'h0, z_i};
         if (a_i && !a_q) b_at_rise_o <= b_i;
      end
   end
endmodule

// >>> gear_and_pulse_output_divider_test.sv
// Self-checking bench for the gear and pulse divider
`timescale 1ns/1ps
`include "gpd_map.svh"
module gear_and_pulse_output_divider_test;
   import gpd_pkg::*;
   logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, step, dir, irq, step_dir;
   logic enc_z, scl_z, ra, rb, rz, hs_go, hs_rev, cmd_p, cmd_s, hs_busy, b_rise;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  hs_n, hs_gap;
   logic [15:0] edges, zc, e0, z0, zs;
   logic [1:0]  enc_ix, scl_ix, lv;
   int err_total, samples_checked, step_cnt, s0, acc_c, acc_r, gnum, gden, n;
   logic [11:0] r_off [7] = '{`GPD_OFF_GEAR_NUM, `GPD_OFF_GEAR_DEN, `GPD_OFF_OUT_CNT,
      `GPD_OFF_OUT_DEN, `GPD_OFF_OUT_LOGIC, `GPD_OFF_ACTIVE, 12'h040};
   logic [31:0] r_val [7] = '{`GPD_RST_GEAR_NUM, `GPD_RST_GEAR_DEN, `GPD_RST_OUT_CNT,
      `GPD_RST_OUT_DEN, 32'h0, 32'h0, 32'h0};
   logic [31:0] s_max [3] = '{`GPD_GEAR_MAX, `GPD_OUT_CNT_MAX, `GPD_OUT_DEN_MAX};
   gpd_top #(.ENC_RES(32'h0000_0040)) u_gpd_top (.ref_clk_i(ref_clk), .resetn_i(resetn),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .cmd_pulse_i(cmd_p), .cmd_sign_i(cmd_s), .pos_cmd_step_o(step), .pos_cmd_dir_o(dir),
      .enc_a_i(enc_ix[1]), .enc_b_i(enc_ix[1] ^ enc_ix[0]), .enc_z_i(enc_z),
      .scl_a_i(scl_ix[1]), .scl_b_i(scl_ix[1] ^ scl_ix[0]), .scl_z_i(scl_z),
      .regen_a_phase_o(ra), .regen_b_phase_o(rb), .regen_z_phase_o(rz), .irq_o(irq));
   gpd_host_model u_gpd_host_model (.ref_clk_i(ref_clk), .resetn_i(resetn), .start_i(hs_go),
      .rev_i(hs_rev), .n_i(hs_n), .gap_i(hs_gap), .a_i(ra), .b_i(rb), .z_i(rz),
      .cmd_pulse_o(cmd_p), .cmd_sign_o(cmd_s), .busy_o(hs_busy), .b_at_rise_o(b_rise),
      .edges_o(edges), .zc_o(zc));
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // Direction only stands together with its step, so it is caught there
   always @(posedge ref_clk) begin
      if (step === 1'b1) begin
         step_cnt++;
         step_dir = dir;
      end
   end
   task automatic close_out();
      if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #300000;
      err_total++;
      close_out();
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rd = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // Steps follow the model: remainder is carried between compared bursts and dropped after an unchecked one
   task automatic cmd_run(input int cnt, input int gap, input logic rev, input logic cmp);
      s0 = step_cnt;
      @(posedge ref_clk);
      hs_n <= 8'(cnt); hs_gap <= 8'(gap); hs_rev <= rev; hs_go <= 1'b1;
      @(posedge ref_clk);
      hs_go <= 1'b0;
      @(posedge ref_clk);
      while (hs_busy === 1'b1) @(posedge ref_clk);
      repeat (80) @(posedge ref_clk);
      acc_c += cnt * ((gnum == 0) ? 1 : gnum);
      if (cmp) chk(32'(step_cnt - s0), 32'(acc_c / ((gnum == 0) ? 1 : gden)));
      if (cmp) chk({31'h0, step_dir}, {31'h0, rev});
      acc_c = cmp ? acc_c % ((gnum == 0) ? 1 : gden) : 0;
   endtask
   task automatic src_run(input logic scl, input logic rev, input int nn, input int dd,
                          input logic bchk);
      e0 = edges;
      zs = zc;
      for (int i = 0; i < 8; i++) begin
         @(posedge ref_clk);
         if (scl) scl_ix <= rev ? scl_ix - 2'h1 : scl_ix + 2'h1;
         else enc_ix <= rev ? enc_ix - 2'h1 : enc_ix + 2'h1;
         enc_z <= scl ? (i == 1) : (i == 4);
         scl_z <= scl ? (i == 4) : (i == 1);
         if (i == 3) z0 = zc;
         repeat (3) @(posedge ref_clk);
      end
      repeat (16) @(posedge ref_clk);
      acc_r += 8 * nn;
      chk({16'h0, edges - e0}, 32'(acc_r / dd));
      acc_r = acc_r % dd;
      chk({16'h0, z0 - zs}, 32'h0);
      chk({31'h0, zc != z0}, 32'h1);
      if (bchk) chk({31'h0, b_rise}, {31'h0, ~rev ^ lv[0]});
   endtask
   initial begin
      resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
      pwdata = 32'h0; enc_ix = 2'h0; scl_ix = 2'h0; enc_z = 1'b0; scl_z = 1'b0;
      hs_go = 1'b0; hs_rev = 1'b0; hs_n = 8'h0; hs_gap = 8'h0; lv = 2'h0;
      err_total = 0; samples_checked = 0; step_cnt = 0; acc_c = 0; acc_r = 0;
      gnum = 0; gden = 10000;
      void'($urandom(32'h8753));
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      foreach (r_off[i]) begin
         apb(1'b0, r_off[i], 32'h0);
         chk(rd, r_val[i]);
      end
      apb(1'b1, 12'h040, 32'h0000_0003);
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, r_off[(i == 0) ? 0 : i + 1], 32'hFFFF_FFFF);
         apb(1'b0, r_off[(i == 0) ? 0 : i + 1], 32'h0);
         chk(rd, s_max[i]);
      end
      apb(1'b1, `GPD_OFF_GEAR_NUM, 32'h0);
      apb(1'b1, `GPD_OFF_OUT_DEN, 32'h0);
      n = 2 + $urandom % 5;
      cmd_run(n, 6 + $urandom % 8, 1'b0, 1'b1);
      cmd_run(n, 6 + $urandom % 8, 1'b1, 1'b1);
      // Ratio kept within the permitted span by the configuring side
      apb(1'b1, `GPD_OFF_GEAR_NUM, 32'h3);
      apb(1'b1, `GPD_OFF_GEAR_DEN, 32'h2);
      gnum = 3;
      gden = 2;
      cmd_run(5, 6 + $urandom % 8, 1'b0, 1'b1);
      cmd_run(3, 6 + $urandom % 8, 1'b0, 1'b1);
      apb(1'b0, `GPD_OFF_STATUS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, `GPD_OFF_GEAR_NUM, 32'h8);
      apb(1'b1, `GPD_OFF_GEAR_DEN, 32'h1);
      gnum = 8;
      cmd_run(8, 1, 1'b0, 1'b0);
      apb(1'b0, `GPD_OFF_STATUS, 32'h0);
      chk(rd, 32'h1);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, `GPD_OFF_IRQ_MASK, 32'h3);
      @(posedge ref_clk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, `GPD_OFF_STATUS, 32'h1);
      @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, `GPD_OFF_CTRL, 32'h1);
      apb(1'b1, `GPD_OFF_GEAR_NUM, 32'h0);
      gnum = 0;
      apb(1'b0, `GPD_OFF_STATUS, 32'h0);
      chk(rd, 32'h2);
      chk({31'h0, irq}, 32'h1);
      src_run(1'b0, 1'b0, 1, 1, 1'b1);
      apb(1'b1, `GPD_OFF_OUT_CNT, 32'h8);
      src_run(1'b0, 1'b0, 1, 1, 1'b1);
      apb(1'b1, `GPD_OFF_CTRL, 32'h3);
      src_run(1'b0, 1'b0, 32, 64, 1'b1);
      apb(1'b1, `GPD_OFF_OUT_DEN, 32'h20);
      apb(1'b1, `GPD_OFF_CTRL, 32'h3);
      src_run(1'b0, 1'b0, 8, 32, 1'b0);
      apb(1'b1, `GPD_OFF_OUT_DEN, 32'h0);
      for (int v = 0; v < 4; v++) begin
         lv = 2'(v);
         apb(1'b1, `GPD_OFF_OUT_LOGIC, {30'h0, lv});
         apb(1'b1, `GPD_OFF_CTRL, 32'h3);
         apb(1'b0, `GPD_OFF_ACTIVE, 32'h0);
         chk(rd, {29'h0, lv[1], lv});
         repeat (4) @(posedge ref_clk);
         src_run(lv[1], 1'($urandom), lv[1] ? 1 : 32, lv[1] ? 1 : 64, 1'b1);
      end
      close_out();
   end
endmodule
